// ---- hdl/scdp_pkg.sv ----
// Notes on behaviour
// - The sampling clock comes from the full-rate input or the high-frequency input, full-rate after reset.
// - The high-frequency input is first divided by four in a fixed predivider.
// - One register holds a divide ratio of one to eight that serves both clock sources.
// - Any ratio other than one turns the duty cycle stabilizer on whatever its enable says.
// - Two bits choose resync on every reference pulse or only on the first one after a write.
// - An accepted reference pulse puts the divider counter back to its initial state.
// - The active stabilizer keeps the rising edge and rebuilds the falling edge for 50% duty.
// - The stabilizer loop is not relied upon below 40 MHz nominal.
// - While the stabilizer is unlocked it is bypassed and the divided clock shows through with its own duty.
// - Power-down is entered by a register request or by the power-down pin driven high.
// - Driving the power-down pin low brings the device back to the mode set in the power register.
// - Power-down shuts off reference, reference buffer, bias and internal clock.
// - Software can also pick standby, which keeps the reference powered for a quicker wake.
package scdp_pkg;

  // register map
  localparam logic [7:0] SCDP_ADDR_DIV_RATIO = 8'h08;
  localparam logic [7:0] SCDP_ADDR_INPUT_SEL = 8'h09;
  localparam logic [7:0] SCDP_ADDR_DCS_CTRL  = 8'h0b;
  localparam logic [7:0] SCDP_ADDR_POWER     = 8'h0c;
  localparam logic [7:0] SCDP_ADDR_STATUS    = 8'h0d;
  localparam logic [7:0] SCDP_ADDR_RESYNC    = 8'h3a;

  // field layout
  localparam int SCDP_RATIO_W          = 3;
  localparam int SCDP_SEL_HF_BIT       = 0;
  localparam int SCDP_DCS_EN_BIT       = 0;
  localparam int SCDP_RESYNC_EN_BIT    = 1;
  localparam int SCDP_RESYNC_EVERY_BIT = 2;
  localparam int SCDP_PREDIV_W         = 2;
  localparam int SCDP_PERIOD_W         = 16;

  // reset values
  localparam logic [2:0] SCDP_RATIO_RST  = 3'h0;
  localparam logic       SCDP_SEL_RST    = 1'b0;
  localparam logic       SCDP_DCS_EN_RST = 1'b1;

  // timing
  localparam int SCDP_CLK_MHZ          = 100;
  localparam int SCDP_DCS_MIN_RATE_MHZ = 40;
  localparam int SCDP_RELOCK_MIN_NS    = 1500;
  localparam int SCDP_RELOCK_MAX_NS    = 5000;
  localparam int SCDP_RELOCK_MIN_CYC   = (SCDP_RELOCK_MIN_NS * SCDP_CLK_MHZ + 999) / 1000;
  localparam int SCDP_RELOCK_MAX_CYC   = (SCDP_RELOCK_MAX_NS * SCDP_CLK_MHZ) / 1000;
  localparam logic [2:0] SCDP_LOCK_PERIODS = 3'h4;

  typedef enum logic [1:0] {
    SCDP_PWR_NORMAL  = 2'b00,
    SCDP_PWR_DOWN    = 2'b01,
    SCDP_PWR_STANDBY = 2'b10
  } scdp_pwr_t;

endpackage

// ---- hdl/scdp_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser, only the second stage leaves the module
module scdp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  // plain shift, no logic between stages
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end

endmodule

// ---- hdl/scdp_clock_ctrl.sv ----
`timescale 1ns/1ps
module scdp_clock_ctrl
  import scdp_pkg::*;
#(
  parameter int RATE_SCALE = 1000
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       full_rate_clock_in,
  input  wire logic       high_freq_clock_input,
  input  wire logic       sysref_in,
  input  wire logic       power_down_request,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic            sample_clk,
  output logic            ref_enable,
  output logic            ref_buffer_enable,
  output logic            bias_enable,
  output logic            clock_enable
);

  // slowest period the stabilizer accepts, rounded down
  localparam logic [SCDP_PERIOD_W-1:0] MAX_PERIOD =
    SCDP_PERIOD_W'(SCDP_CLK_MHZ * RATE_SCALE / SCDP_DCS_MIN_RATE_MHZ);

  logic [3:0] pin_sync;
  logic       fr_sync, hf_sync, sr_sync, pd_sync;

  // every pin crosses two flops before use
  scdp_sync #(.W(4)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({power_down_request, sysref_in, high_freq_clock_input, full_rate_clock_in}),
    .sync_out (pin_sync)
  );
  assign {pd_sync, sr_sync, hf_sync, fr_sync} = pin_sync;

  // ---------------- registers ----------------
  logic [2:0] ratio_reg, ratio_next;
  logic       sel_hf_reg, sel_hf_next;
  logic       dcs_en_reg, dcs_en_next;
  scdp_pwr_t  pwr_reg, pwr_next;
  logic       rs_en_reg, rs_en_next;
  logic       rs_every_reg, rs_every_next;
  logic       armed_reg, armed_next;
  logic [7:0] rdata_next;
  logic       wr_resync;

  // ---------------- datapath state ----------------
  logic [SCDP_PREDIV_W-1:0] prediv_reg, prediv_next;
  logic [2:0]               div_cnt_reg, div_cnt_next;
  logic                     hf_prev_reg, sr_prev_reg, src_prev_reg;
  logic                     raw_div_reg, raw_div_next;
  logic [SCDP_PERIOD_W-1:0] period_reg, period_next;
  logic [SCDP_PERIOD_W-1:0] last_period_reg, last_period_next;
  logic [SCDP_PERIOD_W-1:0] hi_cnt_reg, hi_cnt_next;
  logic [2:0]               lock_cnt_reg, lock_cnt_next;
  logic                     sample_next;
  logic                     ref_en_next, clk_en_next;

  logic src_level, src_rise, hf_rise, sr_rise, accept;
  logic div_edge, dcs_active, locked, clk_on, pd_active, stby_active, dcs_level;

  // power mode; the pin wins over a register standby request
  always_comb begin
    pd_active   = pd_sync || (pwr_reg == SCDP_PWR_DOWN);
    stby_active = !pd_active && (pwr_reg == SCDP_PWR_STANDBY);
    clk_on      = !pd_active && !stby_active;
    ref_en_next = !pd_active;
    clk_en_next = clk_on;
  end

  // register writes and read-back
  always_comb begin
    ratio_next    = ratio_reg;
    sel_hf_next   = sel_hf_reg;
    dcs_en_next   = dcs_en_reg;
    pwr_next      = pwr_reg;
    rs_en_next    = rs_en_reg;
    rs_every_next = rs_every_reg;
    rdata_next    = reg_rdata;
    wr_resync     = reg_write && (reg_addr == SCDP_ADDR_RESYNC);
    if (reg_write) begin
      unique case (reg_addr)
        SCDP_ADDR_DIV_RATIO: ratio_next  = reg_wdata[SCDP_RATIO_W-1:0];
        SCDP_ADDR_INPUT_SEL: sel_hf_next = reg_wdata[SCDP_SEL_HF_BIT];
        SCDP_ADDR_DCS_CTRL:  dcs_en_next = reg_wdata[SCDP_DCS_EN_BIT];
        SCDP_ADDR_POWER: begin
          unique case (reg_wdata[1:0])
            SCDP_PWR_DOWN:    pwr_next = SCDP_PWR_DOWN;
            SCDP_PWR_STANDBY: pwr_next = SCDP_PWR_STANDBY;
            default:          pwr_next = SCDP_PWR_NORMAL;
          endcase
        end
        SCDP_ADDR_RESYNC: begin
          rs_en_next    = reg_wdata[SCDP_RESYNC_EN_BIT];
          rs_every_next = reg_wdata[SCDP_RESYNC_EVERY_BIT];
        end
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        SCDP_ADDR_DIV_RATIO: rdata_next = {5'h00, ratio_reg};
        SCDP_ADDR_INPUT_SEL: rdata_next = {7'h00, sel_hf_reg};
        SCDP_ADDR_DCS_CTRL:  rdata_next = {7'h00, dcs_en_reg};
        SCDP_ADDR_POWER:     rdata_next = {6'h00, pwr_reg};
        SCDP_ADDR_STATUS:    rdata_next = {4'h0, stby_active, pd_active, locked, dcs_active};
        SCDP_ADDR_RESYNC:    rdata_next = {5'h00, rs_every_reg, rs_en_reg, 1'b0};
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  // source select, predivider, sysref acceptance
  always_comb begin
    hf_rise   = hf_sync && !hf_prev_reg;
    sr_rise   = sr_sync && !sr_prev_reg;
    accept    = sr_rise && rs_en_reg && (rs_every_reg || armed_reg);
    // a write in the same cycle re-arms: the set wins
    armed_next = wr_resync ? 1'b1 : (accept ? 1'b0 : armed_reg);
    if (accept) begin
      prediv_next = '0;
    end else if (hf_rise) begin
      prediv_next = prediv_reg + SCDP_PREDIV_W'(1);
    end else begin
      prediv_next = prediv_reg;
    end
    // msb of a 2-bit counter toggles every two edges: divide by four
    src_level = sel_hf_reg ? prediv_reg[SCDP_PREDIV_W-1] : fr_sync;
    src_rise  = src_level && !src_prev_reg;
  end

  // integer divider, counter wraps after ratio_reg+1 source periods
  always_comb begin
    if (accept || !clk_on) begin
      div_cnt_next = '0;
    end else if (src_rise) begin
      div_cnt_next = (div_cnt_reg == ratio_reg) ? 3'h0 : div_cnt_reg + 3'h1;
    end else begin
      div_cnt_next = div_cnt_reg;
    end
    raw_div_next = src_level && (div_cnt_next == 3'h0) && clk_on;
    div_edge     = raw_div_next && !raw_div_reg;
  end

  // duty cycle stabilizer: period measurement, lock and edge rebuild
  always_comb begin
    dcs_active       = dcs_en_reg || (ratio_reg != SCDP_RATIO_RST);
    locked           = (lock_cnt_reg == SCDP_LOCK_PERIODS);
    period_next      = period_reg;
    last_period_next = last_period_reg;
    lock_cnt_next    = lock_cnt_reg;
    hi_cnt_next      = (hi_cnt_reg != '0) ? hi_cnt_reg - SCDP_PERIOD_W'(1) : hi_cnt_reg;
    if (div_edge) begin
      period_next      = SCDP_PERIOD_W'(1);
      last_period_next = period_reg;
      // a changed period drops lock until it settles again
      if (period_reg == last_period_reg && period_reg <= MAX_PERIOD) begin
        if (!locked) begin
          lock_cnt_next = lock_cnt_reg + 3'h1;
        end
      end else begin
        lock_cnt_next = 3'h0;
      end
      // high for half the last period, rising edge kept as is
      hi_cnt_next = (period_reg > SCDP_PERIOD_W'(1)) ?
                    (period_reg >> 1) : SCDP_PERIOD_W'(1);
    end else if (period_reg != '1) begin
      period_next = period_reg + SCDP_PERIOD_W'(1);
    end
    if (period_reg > MAX_PERIOD) begin
      lock_cnt_next = 3'h0;
    end
    dcs_level = (hi_cnt_next != '0);
    // unlocked or off: pass the divided clock with its own duty
    sample_next = clk_on && ((dcs_active && locked) ? dcs_level : raw_div_next);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ratio_reg         <= SCDP_RATIO_RST;
      sel_hf_reg        <= SCDP_SEL_RST;
      dcs_en_reg        <= SCDP_DCS_EN_RST;
      pwr_reg           <= SCDP_PWR_NORMAL;
      rs_en_reg         <= 1'b0;
      rs_every_reg      <= 1'b0;
      armed_reg         <= 1'b0;
      reg_rdata         <= 8'h00;
      prediv_reg        <= '0;
      div_cnt_reg       <= 3'h0;
      hf_prev_reg       <= 1'b0;
      sr_prev_reg       <= 1'b0;
      src_prev_reg      <= 1'b0;
      raw_div_reg       <= 1'b0;
      period_reg        <= '0;
      last_period_reg   <= '0;
      hi_cnt_reg        <= '0;
      lock_cnt_reg      <= 3'h0;
      sample_clk        <= 1'b0;
      ref_enable        <= 1'b0;
      ref_buffer_enable <= 1'b0;
      bias_enable       <= 1'b0;
      clock_enable      <= 1'b0;
    end else begin
      ratio_reg         <= ratio_next;
      sel_hf_reg        <= sel_hf_next;
      dcs_en_reg        <= dcs_en_next;
      pwr_reg           <= pwr_next;
      rs_en_reg         <= rs_en_next;
      rs_every_reg      <= rs_every_next;
      armed_reg         <= armed_next;
      reg_rdata         <= rdata_next;
      prediv_reg        <= prediv_next;
      div_cnt_reg       <= div_cnt_next;
      hf_prev_reg       <= hf_sync;
      sr_prev_reg       <= sr_sync;
      src_prev_reg      <= src_level;
      raw_div_reg       <= raw_div_next;
      period_reg        <= period_next;
      last_period_reg   <= last_period_next;
      hi_cnt_reg        <= hi_cnt_next;
      lock_cnt_reg      <= lock_cnt_next;
      sample_clk        <= sample_next;
      ref_enable        <= ref_en_next;
      ref_buffer_enable <= clk_en_next;
      bias_enable       <= clk_en_next;
      clock_enable      <= clk_en_next;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sel_after_reset_a: assert property ($fell(reset) |-> !sel_hf_reg)
    else $error("input select not full-rate after reset");

  prediv_step_a: assert property (hf_rise && !accept |=> prediv_reg == $past(prediv_reg) + 2'h1)
    else $error("predivider did not advance on high-frequency edge");

  div_wrap_a: assert property (
    src_rise && clk_on && !accept && div_cnt_reg == ratio_reg |=> div_cnt_reg == 3'h0)
    else $error("divider did not wrap at programmed ratio");

  dcs_forced_a: assert property (
    ratio_reg != 3'h0 && !dcs_en_reg && locked && div_edge && clk_on && !accept
    |=> sample_clk)
    else $error("stabilizer not forced on for ratio above one");

  oneshot_a: assert property (accept && !rs_every_reg && !wr_resync |=> !armed_reg ##1 !accept)
    else $error("one-shot resync accepted a second pulse");

  resync_reset_a: assert property (
    sr_rise && rs_en_reg && rs_every_reg |=> div_cnt_reg == 3'h0 && prediv_reg == '0)
    else $error("accepted reference pulse did not reset divider");

  slow_unlock_a: assert property (period_reg > MAX_PERIOD |=> lock_cnt_reg == 3'h0)
    else $error("stabilizer kept lock on a slow clock");

  bypass_follow_a: assert property (clk_on && !locked |=> sample_clk == raw_div_reg)
    else $error("unlocked stabilizer not bypassed");

  pin_down_a: assert property (pd_sync |=> !clock_enable && !ref_enable && !bias_enable && !sample_clk)
    else $error("power-down pin did not shut blocks off");

  pin_wake_a: assert property (!pd_sync && pwr_reg == SCDP_PWR_NORMAL |=> clock_enable && ref_enable)
    else $error("device did not return to normal operation");

  standby_ref_a: assert property (pwr_reg == SCDP_PWR_STANDBY && !pd_sync |=> ref_enable && !clock_enable)
    else $error("standby did not keep reference alone powered");

  resync_seen_c: cover property (accept);
  lock_seen_c:   cover property (dcs_active && locked && div_edge);
  pin_pd_c:      cover property (pd_sync ##[1:20] !pd_sync);
  standby_c:     cover property (stby_active && locked);

endmodule

// ---- verif/scdp_clock_source.sv ----
`timescale 1ns/1ps
// far-side model: the selected pin carries a set high/low waveform, the other pin
// toggles every cycle, so picking the wrong source shows up as a wrong period
module scdp_clock_source (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sel_hf,
  input  wire logic [7:0] hi_cyc,
  input  wire logic [7:0] lo_cyc,
  input  wire logic       sysref_req,
  output logic            full_rate_clock_in,
  output logic            high_freq_clock_input,
  output logic            sysref_in
);
  logic [7:0] cnt_reg;
  logic       ph_reg;
  logic       fast_reg;
  logic       pend_reg;
  logic [1:0] sref_reg;

  // waveform; >= keeps a shortened span from wrapping the counter
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= 8'h00;
      ph_reg   <= 1'b0;
      fast_reg <= 1'b0;
      pend_reg <= 1'b0;
      sref_reg <= 2'h0;
    end else begin
      if (cnt_reg >= (ph_reg ? hi_cyc : lo_cyc) - 8'h01) begin
        cnt_reg <= 8'h00;
        ph_reg  <= ~ph_reg;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      fast_reg <= ~fast_reg;
      if (sysref_req) begin
        pend_reg <= 1'b1;
      end
      // reference pulse starts with a source rise and is 3 cycles wide
      if (pend_reg && !ph_reg && cnt_reg >= lo_cyc - 8'h01) begin
        pend_reg <= 1'b0;
        sref_reg <= 2'h3;
      end else if (sref_reg != 2'h0) begin
        sref_reg <= sref_reg - 2'h1;
      end
    end
  end

  assign sysref_in             = (sref_reg != 2'h0);
  assign full_rate_clock_in    = sel_hf ? fast_reg : ph_reg;
  assign high_freq_clock_input = sel_hf ? ph_reg : fast_reg;
endmodule

// ---- verif/scdp_clock_ctrl_bench.sv ----
`timescale 1ns/1ps
module scdp_clock_ctrl_bench;
  import scdp_pkg::*;
  logic       clk, reset, sel_hf, sreq, pdn, reg_write, reg_read;
  logic [7:0] hi_cyc, lo_cyc, reg_addr, reg_wdata, reg_rdata, st;
  logic       frc, hfc, sref, sample_clk;
  logic       ref_enable, ref_buffer_enable, bias_enable, clock_enable;
  logic [3:0] en;
  int         err_count, n_checks, hi, per, t_rise, ts, d1, d2, t_a;

  assign en = {ref_enable, ref_buffer_enable, bias_enable, clock_enable};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // time of each reference rise, in cycles
  always @(posedge sref) ts = $time / 10;

  scdp_clock_source src (.clk(clk), .reset(reset), .sel_hf(sel_hf), .hi_cyc(hi_cyc),
    .lo_cyc(lo_cyc), .sysref_req(sreq), .full_rate_clock_in(frc),
    .high_freq_clock_input(hfc), .sysref_in(sref));

  scdp_clock_ctrl #(.RATE_SCALE(10)) dut (.clk(clk), .reset(reset),
    .full_rate_clock_in(frc), .high_freq_clock_input(hfc), .sysref_in(sref),
    .power_down_request(pdn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_clk(sample_clk), .ref_enable(ref_enable),
    .ref_buffer_enable(ref_buffer_enable), .bias_enable(bias_enable),
    .clock_enable(clock_enable));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // read data is taken one edge after the strobe has been seen
  task automatic rdchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] e,
                       input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    #1 chk(reg_rdata & mask, e, m);
  endtask

  // finds the next sample clock rise, then times its high span and period
  task automatic meas();
    int n;
    n = 0;
    #1;
    while (sample_clk !== 1'b0 && n < 500) begin @(posedge clk); #1 n++; end
    while (sample_clk !== 1'b1 && n < 500) begin @(posedge clk); #1 n++; end
    t_rise = $time / 10;
    hi = 0;
    per = 0;
    while (sample_clk === 1'b1 && n < 500) begin @(posedge clk); #1 hi++; end
    while (sample_clk !== 1'b1 && n < 500) begin @(posedge clk); #1 per++; n++; end
    per = per + hi;
    if (n >= 500) chk(8'h01, 8'h00, "sample clock stalled");
  endtask

  // the wait after each change gives the stabilizer its relock time
  task automatic clk_case(input logic hf, input logic [7:0] ratio, input logic [7:0] duty_cycle_stabilizer,
    input logic [7:0] hs, input logic [7:0] ls, input logic [7:0] eh,
    input logic [7:0] ep, input logic [7:0] est);
    @(posedge clk);
    sel_hf <= hf;
    hi_cyc <= hs;
    lo_cyc <= ls;
    wr(SCDP_ADDR_INPUT_SEL, {7'h00, hf});
    wr(SCDP_ADDR_DIV_RATIO, ratio);
    wr(SCDP_ADDR_DCS_CTRL, duty_cycle_stabilizer);
    rdchk(SCDP_ADDR_DIV_RATIO, 8'hff, ratio, "ratio readback");
    repeat (400) @(posedge clk);
    meas();
    chk(hi[7:0], eh, "high span");
    chk(per[7:0], ep, "period");
    rdchk(SCDP_ADDR_STATUS, 8'h01, est, "stabilizer active");
    $display("clock case ratio %0d source hf %0d done", ratio + 1, hf);
  endtask

  // reference pulse aligned to a source rise; delay to the next sample rise
  task automatic pulse(output int d);
    int n;
    n = 0;
    @(posedge clk);
    sreq <= 1'b1;
    @(posedge clk);
    sreq <= 1'b0;
    while (sref !== 1'b1 && n < 100) begin @(posedge clk); #1 n++; end
    meas();
    d = t_rise - ts;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200_000;
    err_count++;
    $display("Error at %0t ns: watchdog expired", $time);
    results();
  end

  initial begin
    {reset, sel_hf, sreq, pdn, reg_write, reg_read} = 6'b10_0000;
    {reg_addr, reg_wdata} = 16'h0000;
    hi_cyc = 8'h03;
    lo_cyc = 8'h07;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({4'h0, en}, 8'h0f, "enables after reset");
    rdchk(SCDP_ADDR_DIV_RATIO, 8'hff, 8'h00, "ratio reset");
    rdchk(SCDP_ADDR_INPUT_SEL, 8'hff, 8'h00, "select reset");
    rdchk(SCDP_ADDR_DCS_CTRL, 8'hff, 8'h01, "stabilizer enable reset");
    rdchk(SCDP_ADDR_RESYNC, 8'hff, 8'h00, "resync reset");
    rdchk(8'h20, 8'hff, 8'h00, "unmapped read");
    $display("reset values done");
    clk_case(1'b0, 8'h00, 8'h01, 8'h03, 8'h07, 8'h05, 8'h0a, 8'h01);
    clk_case(1'b0, 8'h00, 8'h00, 8'h03, 8'h07, 8'h03, 8'h0a, 8'h00);
    clk_case(1'b0, 8'h01, 8'h00, 8'h03, 8'h07, 8'h0a, 8'h14, 8'h01);
    clk_case(1'b1, 8'h00, 8'h01, 8'h02, 8'h02, 8'h08, 8'h10, 8'h01);
    clk_case(1'b1, 8'h01, 8'h00, 8'h01, 8'h01, 8'h08, 8'h10, 8'h01);
    // pin and register power modes
    @(posedge clk);
    pdn <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk({3'h0, sample_clk, en}, 8'h00, "pin power-down");
    @(posedge clk);
    pdn <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk({4'h0, en}, 8'h0f, "pin wake");
    wr(SCDP_ADDR_POWER, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk({4'h0, en}, 8'h00, "register power-down");
    rdchk(SCDP_ADDR_STATUS, 8'h0c, 8'h04, "power-down status");
    wr(SCDP_ADDR_POWER, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk({4'h0, en}, 8'h08, "standby keeps reference");
    rdchk(SCDP_ADDR_STATUS, 8'h0c, 8'h08, "standby status");
    wr(SCDP_ADDR_POWER, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({4'h0, en}, 8'h0f, "register wake");
    $display("power modes done");
    // slow divided clock: no lock, so the input high span shows through
    clk_case(1'b0, 8'h07, 8'h01, 8'h03, 8'h07, 8'h03, 8'h50, 8'h01);
    rdchk(SCDP_ADDR_STATUS, 8'h03, 8'h01, "unlocked status");
    wr(SCDP_ADDR_RESYNC, 8'h06);
    pulse(d1);
    pulse(d2);
    chk(d2[7:0], d1[7:0], "every-pulse realign");
    wr(SCDP_ADDR_RESYNC, 8'h02);
    pulse(d2);
    chk(d2[7:0], d1[7:0], "first pulse realign");
    t_a = t_rise;
    pulse(d2);
    chk(8'((t_rise - t_a) % 80), 8'h00, "one-shot ignores second pulse");
    wr(SCDP_ADDR_RESYNC, 8'h00);
    pulse(d2);
    chk(8'((t_rise - t_a) % 80), 8'h00, "resync off ignores pulse");
    $display("reference resync done");
    results();
  end
endmodule
